// ---- hw/acr_pkg.sv ----
// Shared constants and types of the converter control and readout link.
// Assumes the host end runs on a 125 MHz clock and the device end on the link clock.
package acr_pkg;

	//////////////////////////////////////////////////////////////////////////
	// Timing of the host end, in ns and derived cycles at 125 MHz.
	localparam int CLK_MHZ = 125;
	localparam int SCLK_HALF_NS = 512;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam logic [6:0] SCLK_HALF_LAST = 7'(SCLK_HALF_CYC - 1);
	localparam int EXTCLK_HALF_NS = 40;
	localparam int EXTCLK_HALF_CYC = EXTCLK_HALF_NS * CLK_MHZ / 1000;
	localparam logic [2:0] EXTCLK_HALF_LAST = 3'(EXTCLK_HALF_CYC - 1);

	//////////////////////////////////////////////////////////////////////////
	// Device conversion timing in link clock cycles.
	localparam logic [9:0] CONV_LAST = 10'd199;

	//////////////////////////////////////////////////////////////////////////
	// Output coding.
	localparam logic [23:0] CODE_POS_REF = 24'h780000;
	localparam logic [23:0] CODE_NEG_REF = 24'h87ffff;
	localparam logic [23:0] CODE_ZERO    = 24'h000000;
	localparam logic [23:0] CODE_MAX_POS = 24'h7fffff;
	localparam logic [23:0] CODE_MAX_NEG = 24'h800000;
	localparam logic signed [25:0] CLIP_MAG = 26'((CODE_POS_REF * 106 + 99) / 100);

	// Readback scaling and the low-supply trip with its hysteresis.
	localparam logic [33:0] SUPPLY_SCALE = 34'd786432;
	localparam logic [33:0] MV_PER_V     = 34'd1000;
	localparam logic [44:0] GAIN_SCALE   = 45'd7864320;
	localparam logic [44:0] PPM_PER_UNIT = 45'd1000000;
	localparam logic [12:0] LOW_TRIP_MV  = 13'd4300;
	localparam logic [12:0] LOW_CLEAR_MV = 13'd4350;

	//////////////////////////////////////////////////////////////////////////
	// Serial frame layout.
	localparam int OP_READ_BIT = 7;
	localparam logic [7:0] OP_READ  = 8'h80;
	localparam logic [7:0] OP_WRITE = 8'h00;
	localparam logic [5:0] CMD_LAST_BIT = 6'd7;
	localparam logic [5:0] WR_LAST_BIT  = 6'd15;
	localparam logic [5:0] RD_LAST_BIT  = 6'd39;
	localparam int ST_NEW_BIT = 7;
	localparam int ST_LOW_BIT = 6;

	// Fields of the primary configuration register.
	localparam int CFG_CHOP_BIT   = 0;
	localparam int CFG_CLKOUT_BIT = 1;
	localparam int CFG_CHAN_LSB   = 2;
	localparam logic [7:0] CFG_RST = 8'h02;

	// Host register map on the Wishbone bus.
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_DATA = 8'h08;
	localparam int CTRL_GO_RD_BIT = 0;
	localparam int CTRL_GO_WR_BIT = 1;
	localparam int CTRL_START_BIT = 2;
	localparam int CTRL_SEL_BIT   = 3;

	//////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		CH_INPUT  = 3'b000,
		CH_SUPPLY = 3'b001,
		CH_GAIN   = 3'b010,
		CH_REF    = 3'b011,
		CH_TEMP   = 3'b100
	} acr_chan_e;

	typedef enum logic [0:0] {CV_IDLE = 1'b0, CV_RUN = 1'b1} acr_cv_e;

	typedef enum logic [1:0] {
		SP_CMD = 2'b00, SP_READ = 2'b01, SP_WRITE = 2'b10, SP_DONE = 2'b11
	} acr_sp_e;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00, HS_SHIFT = 2'b01, HS_GAP = 2'b10
	} acr_hs_e;

endpackage : acr_pkg

// ---- hw/acr_link_if.sv ----
// Pins between the converter and its host controller.
// Assumes the bench joins both ends; the shared clock pin is resolved here.
`timescale 1ns/100ps
`default_nettype none
interface acr_link_if;
	logic clock_source_select;
	logic start;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic result_avail_n;
	logic clk_pin_dev_o;
	logic clk_pin_dev_oe;
	logic clk_pin_host_o;
	logic clk_pin_host_oe;
	logic clock_pin_bidir;

	// The driving end wins; an undriven pin reads low.
	assign clock_pin_bidir = clk_pin_dev_oe ? clk_pin_dev_o :
		(clk_pin_host_oe ? clk_pin_host_o : 1'b0);

	modport dev (
		input  clock_source_select, start, sclk, cs_n, mosi,
		output miso, result_avail_n, clk_pin_dev_o, clk_pin_dev_oe
	);
	modport host (
		input  miso, result_avail_n,
		output clock_source_select, start, sclk, cs_n, mosi,
		output clk_pin_host_o, clk_pin_host_oe
	);
endinterface : acr_link_if
`default_nettype wire

// ---- hw/acr_dev.sv ----
// Device end: conversion control, result coding, readback and serial readout.
// Assumes link_clk_i is the selected system clock and the analog inputs are steady.
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1 - Select low: crystal; high: external clock pin.
// RULE2 - Clock out only if enable bit; default set.
// RULE3 - Start high begins converting.
// RULE4 - Start low: finish conversion, then idle.
// RULE5 - New data drives ready low, overwrites old.
// RULE6 - First falling serial edge raises ready.
// RULE7 - Unread data: pulse ready high, then low.
// RULE8 - Fresh-data flag set in status byte.
// RULE9 - Two's complement, reference equals 780000h.
// RULE10 - Overrange clips at full-scale codes.
// RULE11 - Supply code over 786432 gives volts.
// RULE12 - Low supply: zero data, flag set.
// RULE13 - Flag clears 50mV above trip.
// RULE14 - Host clears chopping before internal channels.
// RULE15 - Gain code over 7864320 gives gain.
// RULE16 - Reference code over 786432; floating gives zero.
// RULE17 - Host converts temperature with given coefficients.
// RULE18 - Ready stays high until first result.
module acr_dev
	import acr_pkg::*;
(
	input  wire logic               link_clk_i,
	input  wire logic               link_rst_i,
	input  wire logic signed [25:0] vin_code_i,
	input  wire logic [12:0]        supply_mv_i,
	input  wire logic [12:0]        ref_mv_i,
	input  wire logic [20:0]        gain_ppm_i,
	input  wire logic [23:0]        temp_code_i,
	output logic [7:0]              config_o,
	output logic                    converting_o,
	acr_link_if.dev                 lnk
);

	//////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic [4:0]  pin_meta_ff;
	logic [4:0]  pin_sync_ff;
	logic        sclk_d_ff;
	acr_cv_e     cv_state_ff;
	logic [9:0]  conv_cnt_ff;
	acr_sp_e     sp_state_ff;
	logic [5:0]  bit_cnt_ff;
	logic [7:0]  shin_ff;
	logic [31:0] shout_ff;
	logic        miso_ff;
	logic [7:0]  cfg_ff;
	logic [23:0] result_ff;
	logic [2:0]  res_chan_ff;
	logic        new_ff;
	logic        low_ff;
	logic        ready_n_ff;
	logic        relow_ff;
	logic        clk_tog_ff;
	logic        clk_oe_ff;
	logic        s_start;
	logic        s_sclk;
	logic        s_csn;
	logic        s_mosi;
	logic        s_sel;
	logic        rise;
	logic        fall;
	logic        frame;
	logic        done;
	logic        cmd_end;
	logic        rd_go;
	logic        cfg_wr;
	logic [7:0]  nxt_shift;
	logic [23:0] nxt_code;
	logic [2:0]  chan;

	//////////////////////////////////////////////////////////////////////////
	// Scaling helpers for the readback channels.
	function automatic logic [23:0] scale_mv(input logic [12:0] mv);
		logic [33:0] p;
		p = ({21'h0, mv} * SUPPLY_SCALE) / MV_PER_V;
		return p[23:0];
	endfunction : scale_mv

	function automatic logic [23:0] scale_gain(input logic [20:0] ppm);
		logic [44:0] p;
		p = ({24'h0, ppm} * GAIN_SCALE) / PPM_PER_UNIT;
		return p[23:0];
	endfunction : scale_gain

	// Saturate the ideal code into 24 bits.
	function automatic logic [23:0] clip(input logic signed [25:0] v);
		logic [23:0] c;
		if (v >= CLIP_MAG)
			c = CODE_MAX_POS;
		else if (v <= -CLIP_MAG)
			c = CODE_MAX_NEG;
		else
			c = v[23:0];
		return c;
	endfunction : clip

	//////////////////////////////////////////////////////////////////////////
	// Every host pin crosses two flops; only the second is read.
	assign {s_start, s_sclk, s_csn, s_mosi, s_sel} = pin_sync_ff;

	always_ff @(posedge link_clk_i) begin
		if (link_rst_i) begin
			pin_meta_ff <= 5'h04;
			pin_sync_ff <= 5'h04;
			sclk_d_ff   <= 1'b0;
		end else begin
			pin_meta_ff <= {lnk.start, lnk.sclk, lnk.cs_n, lnk.mosi,
				lnk.clock_source_select};
			pin_sync_ff <= pin_meta_ff;
			sclk_d_ff   <= s_sclk;
		end
	end

	assign rise  = s_sclk & ~sclk_d_ff;
	assign fall  = ~s_sclk & sclk_d_ff;
	assign frame = ~s_csn;
	assign chan  = cfg_ff[CFG_CHAN_LSB +: 3];

	//////////////////////////////////////////////////////////////////////////
	// Conversion sequencer; a dropped start lets the running one finish.
	assign done = (cv_state_ff == CV_RUN) && (conv_cnt_ff == CONV_LAST);

	always_ff @(posedge link_clk_i) begin
		if (link_rst_i) begin
			cv_state_ff <= CV_IDLE;
			conv_cnt_ff <= 10'h000;
		end else begin
			unique case (cv_state_ff)
				CV_IDLE: begin
					conv_cnt_ff <= 10'h000;
					if (s_start)
						cv_state_ff <= CV_RUN; // see RULE3
				end
				CV_RUN: begin
					if (done) begin
						conv_cnt_ff <= 10'h000;
						if (!s_start)
							cv_state_ff <= CV_IDLE; // see RULE4
					end else begin
						conv_cnt_ff <= conv_cnt_ff + 10'h001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (link_rst_i)
			converting_o <= 1'b0;
		else
			converting_o <= (cv_state_ff == CV_RUN);
	end

	//////////////////////////////////////////////////////////////////////////
	// Low-supply flag with hysteresis so it does not chatter at the trip.
	always_ff @(posedge link_clk_i) begin
		if (link_rst_i)
			low_ff <= 1'b0;
		else if (supply_mv_i < LOW_TRIP_MV)
			low_ff <= 1'b1; // see RULE12
		else if (supply_mv_i >= LOW_CLEAR_MV)
			low_ff <= 1'b0; // see RULE13
	end

	// Code of the selected channel; unused channel codes read as zero.
	always_comb begin
		unique case (chan)
			CH_INPUT:  nxt_code = clip(vin_code_i); // see RULE9, RULE10
			CH_SUPPLY: nxt_code = low_ff ? CODE_ZERO : scale_mv(supply_mv_i); // see RULE11, RULE12
			CH_GAIN:   nxt_code = scale_gain(gain_ppm_i); // see RULE15
			CH_REF:    nxt_code = scale_mv(ref_mv_i); // see RULE16
			CH_TEMP:   nxt_code = temp_code_i;
			default:   nxt_code = CODE_ZERO;
		endcase
	end

	// A new result replaces the previous one whether it was read or not.
	always_ff @(posedge link_clk_i) begin
		if (link_rst_i) begin
			result_ff   <= CODE_ZERO;
			res_chan_ff <= 3'h0;
		end else if (done) begin
			result_ff   <= nxt_code; // see RULE5
			res_chan_ff <= chan;
		end
	end

	// Fresh flag: a result landing with the read still sets it.
	always_ff @(posedge link_clk_i) begin
		if (link_rst_i)
			new_ff <= 1'b0;
		else if (done)
			new_ff <= 1'b1; // see RULE8
		else if (rd_go)
			new_ff <= 1'b0;
	end

	//////////////////////////////////////////////////////////////////////////
	// Ready line: low on a result, high on the first serial fall of a frame.
	always_ff @(posedge link_clk_i) begin
		if (link_rst_i) begin
			ready_n_ff <= 1'b1; // see RULE18
			relow_ff   <= 1'b0;
		end else if (done) begin
			ready_n_ff <= ~ready_n_ff; // see RULE5
			relow_ff   <= ~ready_n_ff; // see RULE7
		end else if (relow_ff) begin
			ready_n_ff <= 1'b0; // see RULE7
			relow_ff   <= 1'b0;
		end else if (frame && fall && bit_cnt_ff == 6'd1) begin
			ready_n_ff <= 1'b1; // see RULE6
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Serial command decode; bits are taken on the synchronised rising edge.
	assign nxt_shift = {shin_ff[6:0], s_mosi};
	assign cmd_end = frame && rise && sp_state_ff == SP_CMD && bit_cnt_ff == CMD_LAST_BIT;
	assign rd_go = cmd_end && nxt_shift[OP_READ_BIT];
	assign cfg_wr = frame && rise && sp_state_ff == SP_WRITE && bit_cnt_ff == WR_LAST_BIT;

	always_ff @(posedge link_clk_i) begin
		if (link_rst_i || !frame) begin
			sp_state_ff <= SP_CMD;
			bit_cnt_ff  <= 6'h00;
			shin_ff     <= 8'h00;
		end else if (rise) begin
			shin_ff    <= nxt_shift;
			bit_cnt_ff <= bit_cnt_ff + 6'h01;
			if (cmd_end)
				sp_state_ff <= rd_go ? SP_READ : SP_WRITE;
			else if (cfg_wr)
				sp_state_ff <= SP_DONE;
		end
	end

	// Status byte and result shift out MSB first on falling edges.
	always_ff @(posedge link_clk_i) begin
		if (link_rst_i) begin
			shout_ff <= 32'h0000_0000;
			miso_ff  <= 1'b0;
		end else if (rd_go) begin
			shout_ff <= {new_ff, low_ff, 3'b000, res_chan_ff, result_ff}; // see RULE8
		end else if (frame && fall && sp_state_ff == SP_READ) begin
			miso_ff  <= shout_ff[31];
			shout_ff <= {shout_ff[30:0], 1'b0};
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (link_rst_i)
			cfg_ff <= CFG_RST; // see RULE2
		else if (cfg_wr)
			cfg_ff <= nxt_shift;
	end

	//////////////////////////////////////////////////////////////////////////
	// Clock output at half the system clock, only on the crystal source.
	always_ff @(posedge link_clk_i) begin
		if (link_rst_i) begin
			clk_tog_ff <= 1'b0;
			clk_oe_ff  <= 1'b0;
		end else begin
			clk_tog_ff <= ~clk_tog_ff;
			clk_oe_ff  <= ~s_sel & cfg_ff[CFG_CLKOUT_BIT]; // see RULE1, RULE2
		end
	end

	assign config_o           = cfg_ff;
	assign lnk.miso           = miso_ff;
	assign lnk.result_avail_n = ready_n_ff;
	assign lnk.clk_pin_dev_o  = clk_tog_ff;
	assign lnk.clk_pin_dev_oe = clk_oe_ff;

endmodule : acr_dev
`default_nettype wire

// ---- hw/acr_host.sv ----
// Host end: Wishbone registers that drive frames on the serial link.
// Assumes a classic Wishbone master on clk_i and the device end on the link.
`timescale 1ns/100ps
`default_nettype none
module acr_host
	import acr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	acr_link_if.host         lnk
);

	logic [1:0]  in_meta_ff;
	logic [1:0]  in_sync_ff;
	logic        start_ff;
	logic        sel_ff;
	logic [7:0]  cfg_tx_ff;
	acr_hs_e     hs_state_ff;
	logic [6:0]  half_ff;
	logic [5:0]  bit_ff;
	logic [5:0]  last_ff;
	logic        is_rd_ff;
	logic [15:0] tx_ff;
	logic [31:0] rx_ff;
	logic [23:0] data_ff;
	logic [7:0]  stat_ff;
	logic        cs_n_ff;
	logic        sclk_ff;
	logic        mosi_ff;
	logic [2:0]  ext_cnt_ff;
	logic        ext_clk_ff;
	logic        wb_req;
	logic        wr_ctrl;
	logic        go_rd;
	logic        go_wr;
	logic [31:0] nxt_rx;
	logic [7:0]  safe_cfg;

	//////////////////////////////////////////////////////////////////////////
	// Ready line and serial data cross two flops each.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_meta_ff <= 2'h2;
			in_sync_ff <= 2'h2;
		end else begin
			in_meta_ff <= {lnk.result_avail_n, lnk.miso};
			in_sync_ff <= in_meta_ff;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Slave answers one cycle after the request and drops ack the next.
	assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_ctrl = wb_req & wb_we_i & (wb_adr_i == ADR_CTRL);
	assign go_rd   = wr_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_GO_RD_BIT];
	assign go_wr   = wr_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_GO_WR_BIT];

	// Chopping is forced off whenever an internal channel is selected.
	always_comb begin
		safe_cfg = wb_dat_i[15:8];
		if (safe_cfg[CFG_CHAN_LSB +: 3] != CH_INPUT)
			safe_cfg[CFG_CHOP_BIT] = 1'b0; // see RULE14
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
			start_ff  <= 1'b0;
			sel_ff    <= 1'b0;
			cfg_tx_ff <= CFG_RST;
		end else begin
			wb_ack_o <= wb_req;
			if (wr_ctrl && wb_sel_i[0]) begin
				start_ff <= wb_dat_i[CTRL_START_BIT];
				sel_ff   <= wb_dat_i[CTRL_SEL_BIT];
			end
			if (wr_ctrl && wb_sel_i[1])
				cfg_tx_ff <= safe_cfg;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					ADR_CTRL: wb_dat_o <= {16'h0000, cfg_tx_ff, 4'h0, sel_ff, start_ff, 2'b00};
					ADR_STAT: wb_dat_o <= {16'h0000, stat_ff, 6'h00, in_sync_ff[1],
						hs_state_ff != HS_IDLE};
					ADR_DATA: wb_dat_o <= {8'h00, data_ff};
					default:  wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Frame engine: mosi moves after a fall, miso is taken before a fall.
	assign nxt_rx = {rx_ff[30:0], in_sync_ff[0]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hs_state_ff <= HS_IDLE;
			half_ff <= 7'h00;
			bit_ff  <= 6'h00;
			last_ff <= 6'h00;
			is_rd_ff <= 1'b0;
			tx_ff   <= 16'h0000;
			rx_ff   <= 32'h0000_0000;
			data_ff <= 24'h000000;
			stat_ff <= 8'h00;
			cs_n_ff <= 1'b1;
			sclk_ff <= 1'b0;
			mosi_ff <= 1'b0;
		end else begin
			unique case (hs_state_ff)
				HS_IDLE: begin
					half_ff <= 7'h00;
					bit_ff  <= 6'h00;
					if (go_rd || go_wr) begin
						hs_state_ff <= HS_SHIFT;
						is_rd_ff <= go_rd;
						last_ff <= go_rd ? RD_LAST_BIT : WR_LAST_BIT;
						cs_n_ff <= 1'b0;
						mosi_ff <= go_rd ? OP_READ[7] : OP_WRITE[7];
						tx_ff <= go_rd ? {OP_READ[6:0], 9'h000} :
							{OP_WRITE[6:0], (wb_sel_i[1] ? safe_cfg : cfg_tx_ff), 1'b0};
					end
				end
				HS_SHIFT: begin
					half_ff <= (half_ff == SCLK_HALF_LAST) ? 7'h00 : half_ff + 7'h01;
					if (half_ff == SCLK_HALF_LAST) begin
						sclk_ff <= ~sclk_ff;
						if (sclk_ff) begin
							rx_ff <= nxt_rx;
							if (bit_ff == last_ff) begin
								hs_state_ff <= HS_GAP;
								if (is_rd_ff) begin
									stat_ff <= nxt_rx[31:24]; // see RULE8
									data_ff <= nxt_rx[23:0];
								end
							end else begin
								bit_ff  <= bit_ff + 6'h01;
								mosi_ff <= tx_ff[15];
								tx_ff   <= {tx_ff[14:0], 1'b0};
							end
						end
					end
				end
				HS_GAP: begin
					half_ff <= (half_ff == SCLK_HALF_LAST) ? 7'h00 : half_ff + 7'h01;
					if (half_ff == SCLK_HALF_LAST) begin
						cs_n_ff <= 1'b1; // High a full half before idle.
						if (cs_n_ff)
							hs_state_ff <= HS_IDLE;
					end
				end
				default: hs_state_ff <= HS_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// External clock for the device, driven only when it is selected.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_cnt_ff <= 3'h0;
			ext_clk_ff <= 1'b0;
		end else if (ext_cnt_ff == EXTCLK_HALF_LAST) begin
			ext_cnt_ff <= 3'h0;
			ext_clk_ff <= ~ext_clk_ff;
		end else begin
			ext_cnt_ff <= ext_cnt_ff + 3'h1;
		end
	end

	assign lnk.clock_source_select = sel_ff;
	assign lnk.clk_pin_host_o  = ext_clk_ff;
	assign lnk.clk_pin_host_oe = sel_ff; // see RULE1
	assign lnk.start = start_ff;
	assign lnk.sclk  = sclk_ff;
	assign lnk.cs_n  = cs_n_ff;
	assign lnk.mosi  = mosi_ff;

endmodule : acr_host
`default_nettype wire

// ---- verification/acr_checker.sv ----
// Concurrent checks on the pins between the converter and its host controller.
// Assumes the bench hands in both clocks, resets, config and run flag.
`timescale 1ns/100ps
`default_nettype none
module acr_checker
	import acr_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       link_clk_i,
	input wire logic       link_rst_i,
	input wire logic       clock_source_select,
	input wire logic       start,
	input wire logic       sclk,
	input wire logic       cs_n,
	input wire logic       result_avail_n,
	input wire logic       clk_pin_dev_oe,
	input wire logic [7:0] config_o,
	input wire logic       converting_o
);
	//////////////////////////////////////////////////////////////////////////
	// Rises in a frame; steady between rises, so the link domain may read it.
	logic [5:0] rise_cnt_ff;
	logic       sclk_ff;
	always_ff @(posedge clk_i) begin
		sclk_ff <= sclk;
		if (rst_i || cs_n) rise_cnt_ff <= 6'h00;
		else if (sclk && !sclk_ff) rise_cnt_ff <= rise_cnt_ff + 6'h01;
	end

	//////////////////////////////////////////////////////////////////////////
	property p_frame_len;
		@(posedge clk_i) disable iff (rst_i) $rose(cs_n) |-> rise_cnt_ff inside {6'h10, 6'h28};
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("bad frame length");
	property p_ext_clk;
		@(posedge link_clk_i) disable iff (link_rst_i) clock_source_select [*6] |-> !clk_pin_dev_oe;
	endproperty
	a_ext_clk: assert property (p_ext_clk) else $error("device drives clock pin");
	property p_clkout_on;
		@(posedge link_clk_i) disable iff (link_rst_i)
		(!clock_source_select && config_o[CFG_CLKOUT_BIT]) [*6] |-> clk_pin_dev_oe;
	endproperty
	a_clkout_on: assert property (p_clkout_on) else $error("clock out missing");
	property p_clkout_off;
		@(posedge link_clk_i) disable iff (link_rst_i)
		!config_o[CFG_CLKOUT_BIT] [*6] |-> !clk_pin_dev_oe;
	endproperty
	a_clkout_off: assert property (p_clkout_off) else $error("clock out not disabled");
	property p_start_run;
		@(posedge link_clk_i) disable iff (link_rst_i) start [*6] |-> converting_o;
	endproperty
	a_start_run: assert property (p_start_run) else $error("not converting");
	property p_stop;
		@(posedge link_clk_i) disable iff (link_rst_i) !start [*6] |-> ##[0:200] !converting_o;
	endproperty
	a_stop: assert property (p_stop) else $error("conversion did not stop");
	property p_ready_cause;
		@(posedge link_clk_i) disable iff (link_rst_i)
		$fell(result_avail_n) |-> $past(converting_o) || $past(converting_o, 2);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without result");
	property p_read_clears;
		@(posedge link_clk_i) disable iff (link_rst_i)
		!result_avail_n && !cs_n && $fell(sclk) && rise_cnt_ff == 6'h01 |-> ##[1:6] result_avail_n;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("ready not released");
	property p_pulse;
		@(posedge link_clk_i) disable iff (link_rst_i) $rose(result_avail_n) && cs_n |=> !result_avail_n;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready pulse too long");

	// Main scenarios reached.
	c_pulse: cover property (@(posedge link_clk_i) $rose(result_avail_n) && cs_n);
	c_read: cover property (@(posedge clk_i) $rose(cs_n) && rise_cnt_ff == 6'h28);
	c_stop: cover property (@(posedge link_clk_i) $fell(converting_o));
endmodule : acr_checker
`default_nettype wire

// ---- verification/tb_adc_conversion_control_readout.sv ----
// Bench joining host and device ends; drives the host over Wishbone.
// Assumes the package constants; frames are slow, so waits are long but bounded.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_conversion_control_readout;
	import acr_pkg::*;
	logic clk_i, rst_i, link_clk_i, link_rst_i, wb_cyc, wb_stb, wb_we, wb_ack, conv_o;
	logic [7:0]         wb_adr, cfg_o;
	logic [31:0]        wb_dat, wb_rdat, q, keep;
	logic signed [25:0] vin;
	logic [12:0]        supply_mv, ref_mv;
	logic [20:0]        gain_ppm;
	int                 num_errors, cmp_count;
	logic signed [25:0] vtab [4] = '{26'sd7864320, -26'sd7864321, 26'sd8336180, -26'sd8336180};
	logic [23:0]        etab [4] = '{24'h780000, 24'h87ffff, 24'h7fffff, 24'h800000};

	//////////////////////////////////////////////////////////////////////////
	// Both ends across the interface, with the checker beside it.
	acr_link_if lnk();
	acr_host i_acr_host(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hf),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .lnk(lnk.host));
	acr_dev i_acr_dev(.link_clk_i(link_clk_i), .link_rst_i(link_rst_i), .vin_code_i(vin),
		.supply_mv_i(supply_mv), .ref_mv_i(ref_mv), .gain_ppm_i(gain_ppm),
		.temp_code_i(vin[23:0]), .config_o(cfg_o), .converting_o(conv_o), .lnk(lnk.dev));
	acr_checker i_acr_checker(.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
		.link_rst_i(link_rst_i), .clock_source_select(lnk.clock_source_select),
		.start(lnk.start), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
		.result_avail_n(lnk.result_avail_n), .clk_pin_dev_oe(lnk.clk_pin_dev_oe),
		.config_o(cfg_o), .converting_o(conv_o));

	// Link clock edges fall on 125 MHz falling edges, never on its rising edges, so no sampling race.
	always #4 clk_i = ~clk_i;
	always #40 link_clk_i = ~link_clk_i;
	initial begin
		link_clk_i = 1'b0;
		link_rst_i = 1'b1;
		repeat (4) @(posedge link_clk_i);
		link_rst_i <= 1'b0;
	end

	//////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic fail_wait();
		num_errors++;
		$display("MISMATCH wait expected done seen timeout");
		tally_and_finish();
	endtask : fail_wait

	// One classic cycle; entered just after a rising edge, ends one edge after ack.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		@(posedge clk_i);
		while (wb_ack !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		if (n >= 20) fail_wait();
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// Control write keeping the start and select levels, then wait for busy to clear.
	task automatic ctrl(input logic [31:0] v);
		int n;
		n = 0;
		wb(1'b1, ADR_CTRL, v | keep, q);
		repeat (4) @(posedge clk_i);
		q = 32'h1;
		while (q[0] !== 1'b0 && n < 4000) begin
			wb(1'b0, ADR_STAT, 32'h0, q);
			n++;
		end
		if (n >= 4000) fail_wait();
	endtask : ctrl

	task automatic cfg(input logic [7:0] b);
		ctrl({16'h0, b, 8'h02});
		repeat (100) @(posedge clk_i);
	endtask : cfg

	task automatic wait_res(input int n);
		int   k;
		logic p;
		k = 0;
		p = lnk.result_avail_n;
		while (n > 0 && k < 10000) begin
			@(posedge clk_i);
			k++;
			if (p === 1'b1 && lnk.result_avail_n === 1'b0) n--;
			p = lnk.result_avail_n;
		end
		if (n > 0) fail_wait();
	endtask : wait_res

	// Settles, waits for a result, then reads status and result.
	task automatic conv(input logic [23:0] ex, input logic lo);
		repeat (20) @(posedge clk_i);
		wait_res(1);
		ctrl(32'h1);
		wb(1'b0, ADR_STAT, 32'h0, q);
		chk("new_flag", q[8+ST_NEW_BIT], 1'b1);
		chk("low_flag", q[8+ST_LOW_BIT], lo);
		wb(1'b0, ADR_DATA, 32'h0, q);
		chk("result", q[23:0], ex);
	endtask : conv

	//////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("ready_idle", lnk.result_avail_n, 1'b1);
		chk("cfg_default", cfg_o, CFG_RST);
		chk("clkout_default", lnk.clk_pin_dev_oe, 1'b1);
		wb(1'b1, 8'h0c, 32'hffffffff, q);
		wb(1'b0, 8'h0c, 32'h0, q);
		chk("unmapped", q, 32'h0);
	endtask : t_reset

	task automatic t_clock();
		int   tg;
		logic p;
		keep = 32'h8;
		ctrl(32'h0);
		repeat (100) @(posedge clk_i);
		chk("dev_oe", lnk.clk_pin_dev_oe, 1'b0);
		tg = 0;
		p = lnk.clock_pin_bidir;
		repeat (40) begin
			@(posedge clk_i);
			if (lnk.clock_pin_bidir !== p) tg++;
			p = lnk.clock_pin_bidir;
		end
		chk("pin_edges", tg, 8);
		keep = 32'h0;
		cfg(8'h00);
		chk("oe_off", lnk.clk_pin_dev_oe, 1'b0);
		cfg(8'h02);
		chk("oe_on", lnk.clk_pin_dev_oe, 1'b1);
	endtask : t_clock

	task automatic t_run();
		keep = 32'h4;
		ctrl(32'h0);
		wait_res(1);
		chk("running", conv_o, 1'b1);
		for (int i = 0; i < 4; i++) begin
			vin <= vtab[i];
			conv(etab[i], 1'b0);
		end
		cfg(8'h07);
		chk("chop_forced", cfg_o, 8'h06);
		supply_mv <= 13'd4299;
		conv(24'h000000, 1'b1);
		supply_mv <= 13'd4340;
		conv(24'h000000, 1'b1);
		supply_mv <= 13'd5000;
		conv(24'h3c0000, 1'b0);
		cfg(8'h0a);
		conv(24'h780000, 1'b0);
		cfg(8'h0e);
		conv(24'h1e0000, 1'b0);
		cfg(8'h12);
		vin <= 26'sd4660;
		conv(24'h001234, 1'b0);
	endtask : t_run

	// Drop start mid-run: one last result, then ready stays low unread.
	task automatic t_stop();
		int n;
		n = 0;
		keep = 32'h0;
		ctrl(32'h0);
		while (conv_o !== 1'b0 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000) fail_wait();
		repeat (40) @(posedge clk_i);
		chk("last_result", lnk.result_avail_n, 1'b0);
		repeat (4000) @(posedge clk_i);
		chk("stopped", conv_o, 1'b0);
		chk("held_low", lnk.result_avail_n, 1'b0);
	endtask : t_stop

	//////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
		vin = 26'sd0;
		supply_mv = 13'd5000;
		ref_mv = 13'd2500;
		gain_ppm = 21'd1000000;
		keep = 32'h0;
		num_errors = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (100) @(posedge clk_i);
		t_reset();
		t_clock();
		t_run();
		t_stop();
		tally_and_finish();
	end
endmodule : tb_adc_conversion_control_readout
`default_nettype wire
